// File: shared/usbi_regs.svh
`ifndef USBI_REGS_SVH
`define USBI_REGS_SVH

// Register offsets, engine one
`define USBI_DEV1_IEN_OFS   16'hc08c
`define USBI_DEV1_ADDR_OFS  16'hc08e
`define USBI_DEV1_STAT_OFS  16'hc090

// Register offsets, engine two
`define USBI_DEV2_IEN_OFS   16'hc0ac
`define USBI_DEV2_ADDR_OFS  16'hc0ae
`define USBI_DEV2_STAT_OFS  16'hc0b0

// Bit positions shared by enable and status
`define USBI_VBUS_BIT       15
`define USBI_ID_BIT         14
`define USBI_SOF_BIT        9
`define USBI_RST_BIT        8
`define USBI_EP_MSB         7

// Implemented bits; engine two lacks the VBUS and ID positions
`define USBI_DEV1_MASK      16'hc3ff
`define USBI_DEV2_MASK      16'h03ff

// Address field
`define USBI_ADDR_MSB       6

// Reset values
`define USBI_IEN_RST        16'h0000
`define USBI_ADDR_RST       7'h00
`define USBI_STAT_RST       16'h0000

`endif

// File: shared/usbi_pkg.sv
`default_nettype none

package usbi_pkg;

	// One register access from the processor or the parallel host port
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} usbi_bus_req_t;

	// One finished transaction outcome for an endpoint
	typedef struct packed {
		logic       valid;
		logic [2:0] ep;
		logic       ack;
		logic       stall;
		logic       timeout;
		logic       in_err;
		logic       out_err;
		logic       nak;
	} usbi_ep_evt_t;

	// Decoded token address seen on the link
	typedef struct packed {
		logic       valid;
		logic [6:0] addr;
	} usbi_token_t;

	// Registers of one device engine
	typedef struct packed {
		logic [15:0] ien;
		logic [6:0]  addr;
		logic [15:0] flags;
	} usbi_eng_t;

	// Whole state of the top block
	typedef struct packed {
		usbi_eng_t [1:0] eng;
		logic [15:0]     cpu_rdata;
		logic [15:0]     hpi_rdata;
	} usbi_top_st_t;

	// State of the pin edge detector (two pins)
	typedef struct packed {
		logic [1:0][2:0] sh;
		logic [1:0]      lvl;
		logic [1:0]      fill;
		logic            primed;
		logic [1:0]      edge_p;
	} usbi_edge_st_t;

endpackage

`default_nettype wire

// File: src/usbi_pin_edge.sv
`timescale 1ns/1ps
`default_nettype none

module usbi_pin_edge
(
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	input  wire logic [1:0] pin_i,
	output logic      [1:0] edge_o
);
	import usbi_pkg::*;

	usbi_edge_st_t q;
	usbi_edge_st_t d;

	// Three stage shift; a change counts once stages two and three agree
	always_comb
	begin
		d = q;
		d.edge_p = 2'h0;
		for (int i = 0; i < 2; i++)
		begin
			d.sh[i] = {q.sh[i][1:0], pin_i[i]};
			if (q.sh[i][2] == q.sh[i][1])
			begin
				d.lvl[i] = q.sh[i][2];
				// First settled level after reset is no edge
				d.edge_p[i] = q.primed & (q.lvl[i] != q.sh[i][2]);
			end
		end
		// Arm only once stage three holds a real pin sample, so the
		// cleared shift register never looks like a pin change
		if (q.fill != 2'h3)
			d.fill = q.fill + 2'h1;
		d.primed = (q.fill == 2'h3);
	end

	// State register
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			q <= '0;
		else
			q <= d;
	end

	assign edge_o = q.edge_p;

endmodule // usbi_pin_edge

`default_nettype wire

// File: src/usbi_dev_irq.sv
// What this block does
// - Enable bit 9 gates the SOF/EOP received interrupt.
// - Enable bit 8 gates the USB reset detected interrupt.
// - Enable bits 7..0 gate transaction-done of the same endpoint.
// - ACK, STALL, timeout, IN or OUT error raise endpoint done.
// - NAK raises endpoint done when that endpoint's NAK enable is set.
// - Address register holds device address in bits 6..0, write-only.
// - Device address resets to zero.
// - Only traffic to the programmed address is answered.
// - Writing one clears a status flag; zero leaves it.
// - Status is read and cleared from processor and parallel host port.
// - Status bit 15 sets on each VBUS 4.4V crossing, engine one.
// - Status bit 14 sets on each OTG ID edge, engine one.
// - VBUS and ID bits exist only in engine one.
// - Each engine has its own address register, 0xC08E and 0xC0AE.
// - Status holds SOF bit 9, reset bit 8, endpoint done bits 7..0.
// - Enable bits 15 and 14 gate VBUS and ID interrupts, engine one.
`timescale 1ns/1ps
`default_nettype none
`include "usbi_regs.svh"

module usbi_dev_irq
(
	input  wire logic                           sys_clk_i,
	input  wire logic                           reset_i,
	// Processor register port
	input  wire usbi_pkg::usbi_bus_req_t        cpu_req_i,
	output logic                         [15:0] cpu_rdata_o,
	// Parallel host port register port
	input  wire usbi_pkg::usbi_bus_req_t        hpi_req_i,
	output logic                         [15:0] hpi_rdata_o,
	// Engine events, index 0 is engine one
	input  wire logic                    [1:0]  sof_eop_rx_i,
	input  wire logic                    [1:0]  usb_reset_det_i,
	input  wire usbi_pkg::usbi_ep_evt_t  [1:0]  ep_evt_i,
	input  wire logic               [1:0][7:0]  nak_irq_en_i,
	// Token address filter
	input  wire usbi_pkg::usbi_token_t   [1:0]  token_i,
	output logic                         [1:0]  pkt_accept_o,
	output logic                    [1:0][6:0]  dev_addr_o,
	// OTG pins of port A, engine one only
	input  wire logic                           vbus_44_i,
	input  wire logic                           otg_id_i,
	// Interrupt requests
	output logic                         [1:0]  irq_o
);
	import usbi_pkg::*;

	usbi_top_st_t q;
	usbi_top_st_t d;

	logic [1:0]       pin_edge;
	logic [1:0][15:0] set_v;
	logic [1:0][15:0] clr_v;
	logic             ep_done;

	// True when a bus request addresses the given offset
	function automatic logic hit(input usbi_bus_req_t r,
		input logic [15:0] ofs);
		hit = (r.addr == ofs);
	endfunction

	// Offsets of an engine's registers, kind 0 enable, 1 address, 2 status
	function automatic logic [15:0] reg_ofs(input int e, input int kind);
		reg_ofs = 16'h0000;
		if (e == 0)
		begin
			if (kind == 0)
				reg_ofs = `USBI_DEV1_IEN_OFS;
			else if (kind == 1)
				reg_ofs = `USBI_DEV1_ADDR_OFS;
			else
				reg_ofs = `USBI_DEV1_STAT_OFS;
		end
		else
		begin
			if (kind == 0)
				reg_ofs = `USBI_DEV2_IEN_OFS;
			else if (kind == 1)
				reg_ofs = `USBI_DEV2_ADDR_OFS;
			else
				reg_ofs = `USBI_DEV2_STAT_OFS;
		end
	endfunction

	// Implemented bits of an engine
	function automatic logic [15:0] eng_mask(input int e);
		if (e == 0)
			eng_mask = `USBI_DEV1_MASK;
		else
			eng_mask = `USBI_DEV2_MASK;
	endfunction

	// Read data for one request; address registers read as zero
	function automatic logic [15:0] rd_val(input usbi_bus_req_t r,
		input usbi_top_st_t s);
		rd_val = 16'h0000;
		if (hit(r, reg_ofs(0, 0)))
			rd_val = s.eng[0].ien;
		else if (hit(r, reg_ofs(0, 2)))
			rd_val = s.eng[0].flags;
		else if (hit(r, reg_ofs(1, 0)))
			rd_val = s.eng[1].ien;
		else if (hit(r, reg_ofs(1, 2)))
			rd_val = s.eng[1].flags;
	endfunction

	// Write-one-to-clear mask from one port for one engine
	function automatic logic [15:0] clr_of(input usbi_bus_req_t r,
		input int e);
		clr_of = 16'h0000;
		if (r.wr && hit(r, reg_ofs(e, 2)))
			clr_of = r.wdata;
	endfunction

	// VBUS and ID pins are synchronised and turned into edge pulses
	usbi_pin_edge u_pin_edge
	(
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.pin_i     ({otg_id_i, vbus_44_i}),
		.edge_o    (pin_edge)
	);

	// Next state of both engines and of the read data
	always_comb
	begin
		d = q;
		set_v = '0;
		clr_v = '0;
		ep_done = 1'b0;
		for (int e = 0; e < 2; e++)
		begin
			// Event sources into flag set vector
			set_v[e][`USBI_SOF_BIT] = sof_eop_rx_i[e];
			set_v[e][`USBI_RST_BIT] = usb_reset_det_i[e];
			ep_done = ep_evt_i[e].ack | ep_evt_i[e].stall
				| ep_evt_i[e].timeout | ep_evt_i[e].in_err
				| ep_evt_i[e].out_err;
			if (ep_evt_i[e].nak && nak_irq_en_i[e][ep_evt_i[e].ep])
				ep_done = 1'b1;
			if (ep_evt_i[e].valid && ep_done)
				set_v[e][ep_evt_i[e].ep] = 1'b1;
			if (e == 0)
			begin
				set_v[e][`USBI_VBUS_BIT] = pin_edge[0];
				set_v[e][`USBI_ID_BIT] = pin_edge[1];
			end

			// Clears from both ports; a new event wins over a clear
			clr_v[e] = clr_of(cpu_req_i, e) | clr_of(hpi_req_i, e);
			d.eng[e].flags = ((q.eng[e].flags & ~clr_v[e]) | set_v[e])
				& eng_mask(e);

			// Enable writes; processor wins when both ports write
			if (cpu_req_i.wr && hit(cpu_req_i, reg_ofs(e, 0)))
				d.eng[e].ien = cpu_req_i.wdata & eng_mask(e);
			else if (hpi_req_i.wr && hit(hpi_req_i, reg_ofs(e, 0)))
				d.eng[e].ien = hpi_req_i.wdata & eng_mask(e);

			// Device address writes, low seven bits kept
			if (cpu_req_i.wr && hit(cpu_req_i, reg_ofs(e, 1)))
				d.eng[e].addr = cpu_req_i.wdata[`USBI_ADDR_MSB:0];
			else if (hpi_req_i.wr && hit(hpi_req_i, reg_ofs(e, 1)))
				d.eng[e].addr = hpi_req_i.wdata[`USBI_ADDR_MSB:0];
		end

		// Read data registered on each read strobe and then held
		if (cpu_req_i.rd)
			d.cpu_rdata = rd_val(cpu_req_i, q);
		if (hpi_req_i.rd)
			d.hpi_rdata = rd_val(hpi_req_i, q);
	end

	// State register with reset values
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			for (int e = 0; e < 2; e++)
			begin
				q.eng[e].ien <= `USBI_IEN_RST;
				q.eng[e].addr <= `USBI_ADDR_RST;
				q.eng[e].flags <= `USBI_STAT_RST;
			end
			q.cpu_rdata <= 16'h0000;
			q.hpi_rdata <= 16'h0000;
		end
		else
			q <= d;
	end

	// Interrupt request, address filter and register outputs
	always_comb
	begin
		for (int e = 0; e < 2; e++)
		begin
			// Enable bits 15,14,9,8,7..0 gate the matching flags
			irq_o[e] = |(q.eng[e].flags & q.eng[e].ien);
			pkt_accept_o[e] = token_i[e].valid
				&& (token_i[e].addr == q.eng[e].addr);
			dev_addr_o[e] = q.eng[e].addr;
		end
	end

	assign cpu_rdata_o = q.cpu_rdata;
	assign hpi_rdata_o = q.hpi_rdata;

endmodule // usbi_dev_irq

`default_nettype wire

// File: sim/usbi_dev_irq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module usbi_dev_irq_chk
(
	input wire logic                        sys_clk_i,
	input wire logic                        reset_i,
	input wire usbi_pkg::usbi_bus_req_t     cpu_req_i,
	input wire usbi_pkg::usbi_bus_req_t     hpi_req_i,
	input wire logic [15:0]                 cpu_rdata_o,
	input wire logic [15:0]                 hpi_rdata_o,
	input wire usbi_pkg::usbi_token_t [1:0] token_i,
	input wire logic [1:0]                  pkt_accept_o,
	input wire logic [1:0][6:0]             dev_addr_o,
	input wire logic [1:0]                  irq_o
);
	import usbi_pkg::*;
	logic w1, h1, c2, h2;
	logic [6:0] nxt2;
	// Writes to the engine one address register
	assign w1 = cpu_req_i.wr && cpu_req_i.addr == 16'hc08e;
	assign h1 = hpi_req_i.wr && hpi_req_i.addr == 16'hc08e;
	// Writes to the engine two address register; processor wins
	assign c2 = cpu_req_i.wr && cpu_req_i.addr == 16'hc0ae;
	assign h2 = hpi_req_i.wr && hpi_req_i.addr == 16'hc0ae;
	assign nxt2 = c2 ? cpu_req_i.wdata[6:0] : hpi_req_i.wdata[6:0];
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// Filter, address, read-back and interrupt relations
	a_filter_one:
	assert property (pkt_accept_o[0] == (token_i[0].valid
		&& token_i[0].addr == dev_addr_o[0])) else $error("filter one");
	a_filter_two:
	assert property (pkt_accept_o[1] == (token_i[1].valid
		&& token_i[1].addr == dev_addr_o[1])) else $error("filter two");
	a_addr_load:
	assert property (w1 |=> dev_addr_o[0] == $past(cpu_req_i.wdata[6:0]))
		else $error("address one not loaded");
	a_addr2_load:
	assert property (c2 || h2 |=> dev_addr_o[1] == $past(nxt2))
		else $error("addr two");
	a_addr_keep:
	assert property (!(w1 || h1) |=> $stable(dev_addr_o[0]))
		else $error("address changed unasked");
	a_addr_wo:
	assert property (cpu_req_i.rd && cpu_req_i.addr == 16'hc08e |=>
		cpu_rdata_o == 16'h0000) else $error("address readable");
	a_stat_rsv:
	assert property (hpi_req_i.rd && hpi_req_i.addr == 16'hc0b0 |=>
		hpi_rdata_o[15:14] == 2'b00) else $error("engine two pin bits");
	a_irq_fall:
	assert property ($fell(irq_o[0]) |-> $past(cpu_req_i.wr || hpi_req_i.wr))
		else $error("irq dropped without write");
endmodule // usbi_dev_irq_chk
`default_nettype wire

// File: sim/usbi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module usbi_host_model
(
	input  wire logic                    sys_clk_i,
	output usbi_pkg::usbi_token_t [1:0]  token_o,
	output logic [1:0]                   sof_o,
	output logic [1:0]                   rst_o,
	output usbi_pkg::usbi_ep_evt_t [1:0] ep_o
);
	import usbi_pkg::*;
	// Link idle at start
	initial
	begin
		token_o = '0;
		sof_o = '0;
		rst_o = '0;
		ep_o = '0;
	end
	// One-cycle frame, bus reset or endpoint outcome; then SOF and reset drop, endpoint lines invert with valid low
	task automatic ev(input int e, input logic s, r, input logic [9:0] x);
		@(negedge sys_clk_i);
		sof_o[e] = s;
		rst_o[e] = r;
		ep_o[e] = x;
		@(negedge sys_clk_i);
		sof_o[e] = 0;
		rst_o[e] = 0;
		ep_o[e] = ~x & 10'h1ff;
	endtask
	// Token address; a released token shows the inverse address
	task automatic tok(input int e, input logic [6:0] a, input logic v);
		token_o[e] = v ? {1'b1, a} : {1'b0, ~a};
	endtask
endmodule // usbi_host_model
`default_nettype wire

// File: sim/tb_usb_device_irq_and_address.sv
`timescale 1ns/1ps
`default_nettype none
module tb_usb_device_irq_and_address;
	import usbi_pkg::*;
	usbi_bus_req_t creq, hreq;
	usbi_token_t [1:0] tok;
	usbi_ep_evt_t [1:0] ep;
	logic [15:0] crd, hrd, m, s, q[$];
	logic [1:0][7:0] nak;
	logic [1:0][6:0] dad;
	logic [1:0] acc_o, irq, sof, rst;
	logic [6:0] a;
	logic clk, reset, vbus, oid, pc, ph;
	int err_total, checked, i, e;
	usbi_dev_irq dut (.sys_clk_i(clk), .reset_i(reset), .cpu_req_i(creq),
		.cpu_rdata_o(crd), .hpi_req_i(hreq), .hpi_rdata_o(hrd),
		.sof_eop_rx_i(sof), .usb_reset_det_i(rst), .ep_evt_i(ep),
		.nak_irq_en_i(nak), .token_i(tok), .pkt_accept_o(acc_o),
		.dev_addr_o(dad), .vbus_44_i(vbus), .otg_id_i(oid), .irq_o(irq));
	usbi_host_model hm (.sys_clk_i(clk), .token_o(tok), .sof_o(sof),
		.rst_o(rst), .ep_o(ep));
	// Clock
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic print_verdict;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, x);
		checked++;
		if (g !== x)
		begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask
	// One register cycle on the processor or host port
	task automatic acc(input bit h, w, input logic [15:0] ad, d);
		@(negedge clk);
		if (h)
			hreq = '{w, !w, ad, d};
		else
			creq = '{w, !w, ad, d};
		@(negedge clk);
		hreq = '0;
		creq = '0;
	endtask
	task automatic rd(input bit h, input logic [15:0] ad, x);
		q.push_back(x);
		acc(h, 0, ad, 16'h0000);
	endtask
	task automatic fire(input int k);
		if (k == 9)
			hm.ev(0, 1, 0, 0);
		else if (k == 8)
			hm.ev(0, 0, 1, 0);
		else
			hm.ev(0, 0, 0, {1'b1, 3'(k), 6'h20});
	endtask
	// Read answers arrive one cycle after the read edge
	always @(posedge clk)
	begin
		if (pc)
			chk(crd, q.pop_front());
		if (ph)
			chk(hrd, q.pop_front());
		pc <= creq.rd;
		ph <= hreq.rd;
	end
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		print_verdict;
	end
	// Main sequence
	initial
	begin
		void'($urandom(50864));
		{reset, vbus, oid} = 3'h4;
		creq = '0;
		hreq = '0;
		nak = '0;
		repeat (20) @(posedge clk);
		@(negedge clk);
		reset = 0;
		rd(0, 16'hc08e, 16'h0000);
		rd(1, 16'h1234, 16'h0000);
		chk(16'(dad), 16'h0000);
		acc(0, 1, 16'hc08c, 16'hc3ff);
		rd(1, 16'hc08c, 16'hc3ff);
		acc(1, 1, 16'hc0ac, 16'h03ff);
		rd(0, 16'hc0ac, 16'h03ff);
		$display("test 1 done");
		for (e = 0; e < 2; e++)
		begin
			s = 16'hc090 + 16'(e * 32);
			for (i = 0; i < 8; i++)
				hm.ev(e, 0, 0, {1'b1, 3'(i), 6'h20 >> (i % 5)});
			hm.ev(e, 1, 1, 0);
			chk(16'(irq[e]), 16'h0001);
			m = 16'($urandom) & 16'h03ff;
			acc(1, 1, s, m);
			rd(0, s, 16'h03ff & ~m);
			acc(0, 1, s, 16'h03ff);
			hm.ev(e, 0, 0, 10'h341);
			rd(1, s, 16'h0000);
			nak[e][5] = 1;
			hm.ev(e, 0, 0, 10'h341);
			rd(1, s, 16'h0020);
			acc(0, 1, s, 16'h03ff);
		end
		$display("test 2 done");
		for (i = 0; i < 10; i++)
		begin
			acc(0, 1, 16'hc08c, 16'(1 << i));
			fire((i + 1) % 10);
			chk(16'(irq[0]), 16'h0000);
			fire(i);
			chk(16'(irq[0]), 16'h0001);
			acc(1, 1, 16'hc090, 16'h0000);
			chk(16'(irq[0]), 16'h0001);
			acc(0, 1, 16'hc090, 16'hc3ff);
			chk(16'(irq[0]), 16'h0000);
		end
		$display("test 3 done");
		acc(0, 1, 16'hc08c, 16'h8000);
		for (i = 0; i < 4; i++)
		begin
			if (i % 2)
				oid = ~oid;
			else
				vbus = ~vbus;
			repeat (8) @(negedge clk);
			rd(0, 16'hc090, i % 2 ? 16'h4000 : 16'h8000);
			chk(16'(irq[0]), 16'(i % 2 == 0));
			rd(1, 16'hc0b0, 16'h0000);
			acc(0, 1, 16'hc090, 16'hc3ff);
		end
		$display("test 4 done");
		for (e = 0; e < 2; e++)
		begin
			a = 7'($urandom);
			acc(e[0], 1, 16'hc08e + 16'(e * 32), 16'(a));
			hm.tok(e, a, 1);
			@(negedge clk);
			chk(16'(acc_o[e]), 16'h0001);
			hm.tok(e, a ^ 7'h01, 1);
			@(negedge clk);
			chk(16'(acc_o[e]), 16'h0000);
			hm.tok(e, a, 0);
			chk(16'(dad[e]), 16'(a));
		end
		reset = 1;
		@(negedge clk);
		chk(16'(dad), 16'h0000);
		reset = 0;
		$display("test 5 done");
		print_verdict;
	end
endmodule // tb_usb_device_irq_and_address
bind usbi_dev_irq usbi_dev_irq_chk u_chk (.sys_clk_i, .reset_i, .cpu_req_i,
	.hpi_req_i, .cpu_rdata_o, .hpi_rdata_o, .token_i, .pkt_accept_o,
	.dev_addr_o, .irq_o);
`default_nettype wire
